// ==== iio_alu.sv ====
// Purpose: combinational result and flag logic for increment, double-increment and invert
// Assumes: operand and operation are stable while the result is used
// Notes: flags are produced as c, z, n, v; the caller merges them into the status word
`timescale 1ns/1ps
module iio_alu (
    input wire logic [15:0] operand_i, // destination value before the operation
    input wire logic byte_i, // high for byte form
    input wire iio_pkg::iio_op_t op_i, // operation code
    output logic [15:0] result_o, // destination value after the operation
    output logic c_o, // carry flag
    output logic z_o, // zero flag
    output logic n_o, // negative flag
    output logic v_o // overflow flag
);
    // sign of a value in the active width
    function automatic logic sign_of(input logic [15:0] val, input logic is_byte);
        sign_of = is_byte ? val[7] : val[15];
    endfunction : sign_of

    // width-masked value so byte form ignores the upper byte
    function automatic logic [15:0] low_part(input logic [15:0] val, input logic is_byte);
        low_part = is_byte ? {8'h00, val[7:0]} : val;
    endfunction : low_part

    logic [15:0] opnd;
    logic [15:0] all_ones;
    logic [15:0] max_pos;
    assign opnd = low_part(operand_i, byte_i);
    assign all_ones = byte_i ? 16'h00ff : 16'hffff;
    assign max_pos = byte_i ? 16'h007f : 16'h7fff;

    // each increment has its own adder; byte results drop carry-out of bit 7
    always_comb begin
        result_o = opnd;
        c_o = 1'b0;
        z_o = 1'b0;
        v_o = 1'b0;
        unique case (op_i)
            iio_pkg::OP_INC: begin
                result_o = low_part(opnd + 16'h0001, byte_i);
                z_o = (opnd == all_ones);
                c_o = (opnd == all_ones);
                v_o = (opnd == max_pos);
            end
            iio_pkg::OP_DOUBLE_INCREMENT_OP: begin
                result_o = low_part(opnd + 16'h0002, byte_i);
                z_o = (opnd == all_ones - 16'h0001);
                c_o = (opnd == all_ones) || (opnd == all_ones - 16'h0001);
                v_o = (opnd == max_pos) || (opnd == max_pos - 16'h0001);
            end
            iio_pkg::OP_INV: begin
                result_o = low_part(~opnd, byte_i);
                c_o = (low_part(~opnd, byte_i) != 16'h0000);
                z_o = (opnd == all_ones);
                v_o = sign_of(opnd, byte_i);
            end
            default: begin
                result_o = opnd;
            end
        endcase
    end
    assign n_o = sign_of(result_o, byte_i);
endmodule : iio_alu

// ==== iio_core.sv ====
// Purpose: executes increment, double-increment, invert and interrupt enable/disable on a status word
// Assumes: single clock, synchronous active-high reset, Avalon-MM master follows waitrequest
// Notes: interrupt acceptance is withheld for one instruction after enabling
//
// Overview of operation
// - enable operation ORs 0008h into the status word, setting only the enable bit
// - enable operation leaves arithmetic flags and mode bits untouched
// - after enabling, the next instruction runs before any interrupt is taken
// - increment adds one to the destination and overwrites it
// - increment sets Z and C when destination was all ones
// - increment sets V when destination was the largest positive value
// - N follows the sign bit of the result for all three arithmetic operations
// - double-increment adds two to the destination and overwrites it
// - double-increment sets Z when destination was all ones minus one
// - double-increment sets C when destination was either of the top two values
// - double-increment sets V when destination was either of top two positives
// - invert complements every bit of the active width; C means nonzero result, Z means all-ones input
// - invert sets V when the original operand was negative
// - arithmetic operations leave oscillator-off, halt and enable bits untouched
// - disable operation ANDs the status word with 0fff7h, clearing only the enable bit
`timescale 1ns/1ps
module iio_core (
    input wire logic sys_clk_i, // core clock, 10 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [3:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes of a write
    output logic [31:0] avs_readdata_o, // read data, registered
    output logic avs_waitrequest_o, // stall, combinational
    input wire logic irq_pending_i, // interrupt request from a source in the core domain
    input wire logic instr_done_i, // pulse: one instruction has completed
    output logic irq_take_o, // level: an interrupt may be serviced now
    output logic [15:0] status_word_o // current status word, registered
);
    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [15:0] operand;
        logic [15:0] result;
        logic [15:0] status_word;
        logic shield; // irq held off until the next instruction completes
        logic ack; // answer phase of a bus access
        logic [31:0] rdata;
    } iio_state_t;

    iio_state_t cur;
    iio_state_t nxt;

    logic [15:0] alu_result;
    logic alu_c;
    logic alu_z;
    logic alu_n;
    logic alu_v;
    iio_pkg::iio_op_t cmd_op;
    logic cmd_byte;
    logic wr_cmd;

    ////////////////////////////////////////////////////////////////////////////
    // decode of a command write

    // byte enables on lane 0 carry the command; other lanes carry nothing here
    assign wr_cmd = avs_write_i && !cur.ack && (avs_address_i == iio_pkg::REG_COMMAND) && avs_byteenable_i[0];
    assign cmd_byte = avs_writedata_i[iio_pkg::CMD_BYTE_POS];
    always_comb begin
        unique case (avs_writedata_i[iio_pkg::CMD_OP_LSB +: 3])
            3'h1: cmd_op = iio_pkg::OP_INC;
            3'h2: cmd_op = iio_pkg::OP_DOUBLE_INCREMENT_OP;
            3'h3: cmd_op = iio_pkg::OP_INV;
            3'h4: cmd_op = iio_pkg::OP_ENABLE_IRQ_OP;
            3'h5: cmd_op = iio_pkg::OP_DISABLE_IRQ_OP;
            default: cmd_op = iio_pkg::OP_NONE;
        endcase
    end

    iio_alu u_alu (
        .operand_i(cur.operand),
        .byte_i(cmd_byte),
        .op_i(cmd_op),
        .result_o(alu_result),
        .c_o(alu_c),
        .z_o(alu_z),
        .n_o(alu_n),
        .v_o(alu_v)
    );

    // merge word-wise writes with byte enables on the low half
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // every access is answered one cycle after it is seen: waitrequest high first, then low
    always_comb begin
        nxt = cur;
        nxt.ack = (avs_read_i || avs_write_i) && !cur.ack;
        if (instr_done_i) begin
            nxt.shield = 1'b0;
        end
        if (avs_read_i && !cur.ack) begin
            unique case (avs_address_i)
                iio_pkg::REG_OPERAND: nxt.rdata = {16'h0000, cur.operand};
                iio_pkg::REG_STATUS: nxt.rdata = {16'h0000, cur.status_word};
                iio_pkg::REG_RESULT: nxt.rdata = {16'h0000, cur.result};
                default: nxt.rdata = iio_pkg::UNMAPPED_READ;
            endcase
        end
        if (avs_write_i && !cur.ack) begin
            if (avs_address_i == iio_pkg::REG_OPERAND) begin
                nxt.operand = merge16(cur.operand, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == iio_pkg::REG_STATUS) begin
                nxt.status_word = merge16(cur.status_word, avs_writedata_i, avs_byteenable_i);
            end
        end
        if (wr_cmd) begin
            unique case (cmd_op)
                iio_pkg::OP_INC, iio_pkg::OP_DOUBLE_INCREMENT_OP, iio_pkg::OP_INV: begin
                    nxt.result = alu_result;
                    nxt.operand = alu_result; // destination overwritten
                    // mode bits and enable bit keep their value
                    nxt.status_word[iio_pkg::SW_C_POS] = alu_c;
                    nxt.status_word[iio_pkg::SW_Z_POS] = alu_z;
                    nxt.status_word[iio_pkg::SW_N_POS] = alu_n;
                    nxt.status_word[iio_pkg::SW_V_POS] = alu_v;
                end
                iio_pkg::OP_ENABLE_IRQ_OP: begin
                    nxt.status_word = cur.status_word | iio_pkg::SW_SET_GIE;
                    // enable shields when it turns irqs on, and keeps a shield that is already set
                    if (!cur.status_word[iio_pkg::SW_GIE_POS] || cur.shield) begin
                        nxt.shield = 1'b1;
                    end
                end
                iio_pkg::OP_DISABLE_IRQ_OP: begin
                    nxt.status_word = cur.status_word & iio_pkg::SW_CLR_GIE;
                end
                default: begin
                    nxt.result = cur.result;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cur <= '0;
            cur.status_word <= iio_pkg::SW_RESET;
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !cur.ack;
    assign avs_readdata_o = cur.rdata;
    assign status_word_o = cur.status_word;
    // disable takes effect immediately; software must allow for that itself
    assign irq_take_o = cur.status_word[iio_pkg::SW_GIE_POS] && irq_pending_i && !cur.shield;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_enable_irq_op_cmd;
        wr_cmd && cmd_op == iio_pkg::OP_ENABLE_IRQ_OP;
    endsequence

    a_enable_irq_op_sets_gie: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_enable_irq_op_cmd |=> status_word_o == ($past(status_word_o) | 16'h0008))
        else $error("enable did not OR in the enable bit");

    a_enable_irq_op_keeps_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_enable_irq_op_cmd |=> (status_word_o & 16'hfff7) == ($past(status_word_o) & 16'hfff7))
        else $error("enable disturbed other status bits");

    a_enable_irq_op_shield: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_enable_irq_op_cmd and !status_word_o[3]) ##1 !instr_done_i |-> !irq_take_o)
        else $error("interrupt taken before next instruction");

    a_disable_irq_op_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_DISABLE_IRQ_OP |=> status_word_o == ($past(status_word_o) & 16'hfff7))
        else $error("disable did not clear only the enable bit");

    a_inc_result: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_INC && !cmd_byte |=> cur.result == $past(cur.operand) + 16'h0001)
        else $error("word increment result wrong");

    a_inc_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_INC && !cmd_byte |=>
        status_word_o[0] == ($past(cur.operand) == 16'hffff) && status_word_o[1] == status_word_o[0])
        else $error("increment Z or C wrong");

    a_double_increment_op_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_DOUBLE_INCREMENT_OP && cmd_byte |=>
        status_word_o[8] == ($past(cur.operand[7:0]) == 8'h7e || $past(cur.operand[7:0]) == 8'h7f))
        else $error("byte double-increment V wrong");

    a_inv_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_INV && !cmd_byte |=>
        cur.result == ~$past(cur.operand) && status_word_o[0] == (cur.result != 16'h0000))
        else $error("invert result or carry wrong");

    a_mode_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && (cmd_op == iio_pkg::OP_INC || cmd_op == iio_pkg::OP_INV) |=> $stable(status_word_o[5:3]))
        else $error("arithmetic changed mode bits");

    // one-cycle command strobes, so each check sees exactly one launch
    sequence s_inc_cmd;
        wr_cmd && cmd_op == iio_pkg::OP_INC;
    endsequence

    sequence s_double_increment_op_cmd;
        wr_cmd && cmd_op == iio_pkg::OP_DOUBLE_INCREMENT_OP;
    endsequence

    sequence s_inv_cmd;
        wr_cmd && cmd_op == iio_pkg::OP_INV;
    endsequence

    sequence s_disable_irq_op_cmd;
        wr_cmd && cmd_op == iio_pkg::OP_DISABLE_IRQ_OP;
    endsequence

    sequence s_bus_req;
        (avs_read_i || avs_write_i) && !cur.ack;
    endsequence

    // increment in byte form and its overflow flag
    a_inc_byte_res: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inc_cmd |=>
        !$past(cmd_byte) || cur.result == {8'h00, $past(cur.operand[7:0]) + 8'h01})
        else $error("byte increment result wrong");

    a_inc_byte_zc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inc_cmd |=>
        !$past(cmd_byte) || status_word_o[1:0] == {2{$past(cur.operand[7:0]) == 8'hff}})
        else $error("byte increment Z or C wrong");

    a_inc_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inc_cmd |=>
        status_word_o[8] == ($past(cmd_byte) ? $past(cur.operand[7:0]) == 8'h7f : $past(cur.operand) == 16'h7fff))
        else $error("increment V wrong");

    // double increment: sum and the three flags that depend on the top values
    a_double_increment_op_result: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_double_increment_op_cmd |=>
        $past(cmd_byte) || cur.result == $past(cur.operand) + 16'h0002)
        else $error("word double-increment result wrong");

    a_double_increment_op_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_double_increment_op_cmd |=>
        status_word_o[1] == ($past(cmd_byte) ? $past(cur.operand[7:0]) == 8'hfe : $past(cur.operand) == 16'hfffe))
        else $error("double-increment Z wrong");

    a_double_increment_op_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_double_increment_op_cmd |=>
        status_word_o[0] == ($past(cmd_byte) ? $past(cur.operand[7:0]) >= 8'hfe : $past(cur.operand) >= 16'hfffe))
        else $error("double-increment C wrong");

    a_double_increment_op_word_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_double_increment_op_cmd |=>
        $past(cmd_byte) || status_word_o[8] == ($past(cur.operand) inside {16'h7ffe, 16'h7fff}))
        else $error("word double-increment V wrong");

    a_double_increment_op_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_double_increment_op_cmd |=> $stable(status_word_o[5:3]))
        else $error("double-increment changed mode bits");

    // sign flag, byte upper half and destination write shared by the three arithmetic operations
    a_neg_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_inc_cmd or s_double_increment_op_cmd or s_inv_cmd) |=>
        status_word_o[2] == ($past(cmd_byte) ? cur.result[7] : cur.result[15]))
        else $error("N does not follow the result sign");

    a_byte_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_inc_cmd or s_double_increment_op_cmd or s_inv_cmd) |=>
        !$past(cmd_byte) || cur.result[15:8] == 8'h00)
        else $error("byte result has upper bits set");

    a_dest_written: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_inc_cmd or s_double_increment_op_cmd or s_inv_cmd) |=> cur.operand == cur.result)
        else $error("destination not overwritten");

    // invert flags in both forms and the byte-form result
    a_inv_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inv_cmd |=>
        status_word_o[1] == ($past(cmd_byte) ? $past(cur.operand[7:0]) == 8'hff : $past(cur.operand) == 16'hffff))
        else $error("invert Z wrong");

    a_inv_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inv_cmd |=>
        !$past(cmd_byte) || cur.result == {8'h00, ~$past(cur.operand[7:0])})
        else $error("byte invert result wrong");

    a_inv_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_inv_cmd |=>
        status_word_o[8] == ($past(cmd_byte) ? $past(cur.operand[7]) : $past(cur.operand[15])))
        else $error("invert V wrong");

    // interrupt gating around enable and disable
    a_disable_irq_op_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_disable_irq_op_cmd |=> !irq_take_o)
        else $error("interrupt taken after disable");

    a_shield_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_ENABLE_IRQ_OP && !status_word_o[3] |=> cur.shield)
        else $error("enable did not hold off interrupts");

    a_shield_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        instr_done_i && !(wr_cmd && cmd_op == iio_pkg::OP_ENABLE_IRQ_OP) |=> !cur.shield)
        else $error("hold-off outlived the next instruction");

    a_take_open: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !cur.shield && status_word_o[3] && irq_pending_i |-> irq_take_o)
        else $error("enabled pending interrupt not offered");

    // bus answer and unknown commands
    a_bus_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_bus_req |-> avs_waitrequest_o)
        else $error("new access not stalled");

    a_bus_answer: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_bus_req ##1 (avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("access not answered after one wait cycle");

    a_read_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cur.ack && avs_read_i |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    a_unknown_op: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_cmd && cmd_op == iio_pkg::OP_NONE |=> $stable(status_word_o) && $stable(cur.result))
        else $error("unknown command changed state");
endmodule : iio_core

// ==== iio_core_tb_top.sv ====
// Purpose: self-checking bench for the increment, invert and irq-enable execution core
// Assumes: one 10 MHz clock, synchronous active-high reset, Avalon-MM slave answering after one wait cycle
// Notes: status writes keep to the defined flag and mode bits, so undefined bits never reach the model
`timescale 1ns/1ps
module iio_core_tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic [31:0] rdat;
    logic wait_req;
    logic irq_pend = 1'b0;
    logic done = 1'b0;
    logic irq_take;
    logic [15:0] sw_o;
    int n_mismatch = 0;
    int checked = 0;
    logic [15:0] opnd_m = 16'h0000;
    logic [15:0] sw_m = 16'h0000;
    logic [31:0] q;
    logic [15:0] corner [11] = '{16'hffff, 16'h7fff, 16'hfffe, 16'h7ffe, 16'h00ff, 16'h007f, 16'h00fe,
                                 16'h007e, 16'h8000, 16'h0080, 16'h0000};

    // free-running core clock, 100 ns period
    always #50 sys_clk_i = ~sys_clk_i;

    iio_core DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
                  .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
                  .avs_waitrequest_o(wait_req), .irq_pending_i(irq_pend), .instr_done_i(done),
                  .irq_take_o(irq_take), .status_word_o(sw_o));

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // waitrequest and read data are taken at the rising edge itself, before the design's registers move
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        logic busy;
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        be <= b;
        busy = 1'b1;
        while (busy) begin
            @(posedge sys_clk_i);
            busy = wait_req;
            q = rdat;
        end
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus

    task automatic chk_take(input logic exp);
        @(negedge sys_clk_i);
        chk({31'h0, irq_take}, {31'h0, exp});
        @(posedge sys_clk_i);
    endtask : chk_take

    ////////////////////////////////////////////////////////////////////////////////
    // expected result and status word, packed as {result, status}
    function automatic logic [31:0] model(input logic [2:0] op, input logic bw, input logic [15:0] d,
                                          input logic [15:0] sw);
        logic [15:0] m;
        logic [15:0] h;
        logic [15:0] x;
        logic [15:0] r;
        m = bw ? 16'h00ff : 16'hffff;
        h = m >> 1;
        x = d & m;
        case (op)
            3'h1: r = (x + 16'h0001) & m;
            3'h2: r = (x + 16'h0002) & m;
            3'h3: r = ~x & m;
            default: r = x;
        endcase
        if (op inside {3'h1, 3'h2, 3'h3}) begin
            sw[iio_pkg::SW_C_POS] = (op == 3'h1) ? (x == m) : (op == 3'h2) ? (x >= m - 16'h0001) : (r != 0);
            sw[iio_pkg::SW_Z_POS] = (op == 3'h2) ? (x == m - 16'h0001) : (x == m);
            sw[iio_pkg::SW_N_POS] = r[bw ? 7 : 15];
            sw[iio_pkg::SW_V_POS] = (op == 3'h1) ? (x == h) : (op == 3'h2) ? (x == h || x == h - 16'h0001) :
                                    x[bw ? 7 : 15];
        end
        if (op == 3'h4) sw = sw | 16'h0008;
        if (op == 3'h5) sw = sw & 16'hfff7;
        return {r, sw};
    endfunction : model

    ////////////////////////////////////////////////////////////////////////////////
    // register writes that keep the reference copies in step
    task automatic wr_opnd(input logic [15:0] d, input logic [3:0] b);
        bus(1'b1, 4'h0, {16'h0000, d}, b);
        if (b[0]) opnd_m[7:0] = d[7:0];
        if (b[1]) opnd_m[15:8] = d[15:8];
    endtask : wr_opnd

    task automatic wr_sw(input logic [15:0] v);
        bus(1'b1, 4'h4, {16'h0000, v & 16'h013f}, 4'h3);
        sw_m = v & 16'h013f;
    endtask : wr_sw

    // one command, then status port, status register and, for arithmetic ops only, result and operand against the model
    task automatic do_op(input logic [2:0] op, input logic bw);
        logic [31:0] e;
        e = model(op, bw, opnd_m, sw_m);
        bus(1'b1, 4'h8, {27'h0, bw, 1'b0, op}, 4'h1);
        sw_m = e[15:0];
        chk({16'h0000, sw_o}, {16'h0000, sw_m});
        bus(1'b0, 4'h4, 32'h0, 4'h0);
        chk(q, {16'h0000, sw_m});
        if (op inside {3'h1, 3'h2, 3'h3}) begin
            opnd_m = e[31:16];
            bus(1'b0, 4'hc, 32'h0, 4'h0);
            chk(q, {16'h0000, opnd_m});
            bus(1'b0, 4'h0, 32'h0, 4'h0);
            chk(q, {16'h0000, opnd_m});
        end
    endtask : do_op

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end

    // main sequence: reset, corners, random ops, enable shield
    initial begin
        int k;
        logic [15:0] d;
        d = 16'($urandom(32'hc129));
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk({16'h0000, sw_o}, 32'h0000_0000);
        bus(1'b0, 4'h4, 32'h0, 4'h0);
        chk(q, 32'h0000_0000);
        bus(1'b0, 4'h2, 32'h0, 4'h0);
        chk(q, 32'h0000_0000);
        $display("test reset done");
        // every corner value through every arithmetic op in both forms
        for (int i = 0; i < 66; i++) begin
            wr_opnd(corner[i % 11], 4'h3);
            do_op(3'(1 + (i / 11) % 3), 1'(i / 33));
        end
        wr_opnd(16'h0ffe, 4'h3);
        do_op(3'h2, 1'b0);
        $display("test corners done");
        // random operands, lanes, status words and op codes, including unknown ones
        for (int i = 0; i < 200; i++) begin
            k = $urandom_range(0, 15);
            d = (k < 11) ? corner[k] : 16'($urandom);
            if ($urandom_range(0, 3) != 0) wr_opnd(d, ($urandom_range(0, 3) == 0) ? 4'($urandom_range(1, 2)) : 4'h3);
            if (i % 4 == 0) wr_sw(16'($urandom));
            do_op(3'($urandom_range(0, 7)), 1'($urandom_range(0, 1)));
        end
        $display("test random done");
        // interrupt acceptance held off for one instruction after enabling
        wr_sw(16'h0000);
        irq_pend <= 1'b1;
        chk_take(1'b0);
        do_op(3'h4, 1'b0);
        chk_take(1'b0);
        done <= 1'b1;
        @(posedge sys_clk_i);
        done <= 1'b0;
        chk_take(1'b1);
        do_op(3'h4, 1'b0);
        chk_take(1'b1);
        do_op(3'h5, 1'b0);
        chk_take(1'b0);
        done <= 1'b1;
        @(posedge sys_clk_i);
        done <= 1'b0;
        chk_take(1'b0);
        irq_pend <= 1'b0;
        $display("test irq shield done");
        end_sim();
    end
endmodule : iio_core_tb_top

// ==== iio_pkg.sv ====
// Purpose: shared constants and types for the increment/invert/irq-enable execution block
// Assumes: 16-bit status word, flag bits at the positions below
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave
package iio_pkg;
    // status word bit positions
    localparam int unsigned SW_C_POS = 0;
    localparam int unsigned SW_Z_POS = 1;
    localparam int unsigned SW_N_POS = 2;
    localparam int unsigned SW_GIE_POS = 3;
    localparam int unsigned SW_CORE_HALT_BIT_POS = 4;
    localparam int unsigned SW_OSCILLATOR_OFF_BIT_POS = 5;
    localparam int unsigned SW_V_POS = 8;
    // masks applied by the interrupt enable operations, and the status word reset value
    localparam logic [15:0] SW_SET_GIE = 16'h0008;
    localparam logic [15:0] SW_CLR_GIE = 16'hfff7;
    localparam logic [15:0] SW_RESET = 16'h0000;
    // register offsets
    localparam logic [3:0] REG_OPERAND = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COMMAND = 4'h8;
    localparam logic [3:0] REG_RESULT = 4'hc;
    // command register fields and the value read from unmapped offsets
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_BYTE_POS = 4;
    localparam int unsigned CMD_IRQ_POS = 5;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // operation codes
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_INC = 3'h1,
        OP_DOUBLE_INCREMENT_OP = 3'h2,
        OP_INV = 3'h3,
        OP_ENABLE_IRQ_OP = 3'h4,
        OP_DISABLE_IRQ_OP = 3'h5
    } iio_op_t;
endpackage : iio_pkg
